// ### test_ulpi_phy_pin_signalling.sv
// testbench joining the phy end and the link end over the pin interface
`timescale 1ns/10ps
`define CHK(n, e, g) check(n, e, g)
module test_ulpi_phy_pin_signalling;
  import ulpps_pkg::*;
  typedef struct {logic to_link; ulpps_byte_t b; logic last;} ulpps_row_t;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic chip_reset_n = 1'b1;
  logic ref_clock_input = 1'b0;
  logic pclk;
  ulpps_byte_t p_rx_data = 8'h00;
  logic p_rx_valid = 1'b0;
  logic p_rx_ready;
  ulpps_byte_t cmd_data;
  logic cmd_valid;
  logic cmd_last;
  logic cmd_ready = 1'b0;
  ulpps_byte_t tx_data = 8'h00;
  logic tx_valid = 1'b0;
  logic tx_last = 1'b0;
  logic tx_ready;
  ulpps_byte_t l_rx_data;
  logic l_rx_valid;
  int n_errors = 0;
  int compares = 0;
  int k;
  logic [8:0] got_cmd[$];
  logic [8:0] exp_cmd[$];
  ulpps_byte_t got_rx[$];
  ulpps_byte_t exp_rx[$];
  ulpps_row_t rows [8] = '{'{1'b0, 8'h11, 1'b0}, '{1'b0, 8'h22, 1'b0},
    '{1'b0, 8'hc3, 1'b1}, '{1'b1, 8'ha5, 1'b0}, '{1'b1, 8'h5a, 1'b0},
    '{1'b1, 8'hff, 1'b1}, '{1'b0, 8'h80, 1'b1}, '{1'b1, 8'h01, 1'b1}};
  ulpps_if u_ulpps_if ();
  ulpps_phy u_ulpps_phy (.clk_sys(clk_sys), .reset(reset),
    .chip_reset_n(chip_reset_n), .ref_clock_input(ref_clock_input),
    .bus(u_ulpps_if), .phy_interface_clock_out(pclk),
    .rx_data(p_rx_data), .rx_valid(p_rx_valid), .rx_ready(p_rx_ready),
    .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_last(cmd_last),
    .cmd_ready(cmd_ready));
  ulpps_link u_ulpps_link (.clk_sys(clk_sys), .reset(reset),
    .bus(u_ulpps_if), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_last(tx_last), .tx_ready(tx_ready), .rx_data(l_rx_data),
    .rx_valid(l_rx_valid));
  ulpps_props u_ulpps_props (.reset(reset), .ifclk(u_ulpps_if.ifclk),
    .dir(u_ulpps_if.dir), .nxt(u_ulpps_if.nxt), .stp(u_ulpps_if.stp),
    .phy_data_oe(u_ulpps_if.phy_data_oe),
    .link_data_oe(u_ulpps_if.link_data_oe));
  // ****************************************************
  // clocks, stall pattern and monitors
  // ****************************************************
  // 100 ns system clock; reference clock only watched by the phy
  always #50 clk_sys = ~clk_sys;
  always #38.462 ref_clock_input = ~ref_clock_input;
  // command sink stalls every other cycle to exercise back-pressure
  always @(negedge clk_sys) cmd_ready <= ~cmd_ready;
  // collect what each end hands to its user side
  always @(posedge clk_sys) begin
    if (!reset && cmd_valid === 1'b1 && cmd_ready === 1'b1)
      got_cmd.push_back({cmd_last, cmd_data});
    if (!reset && l_rx_valid === 1'b1)
      got_rx.push_back(l_rx_data);
  end
  // ****************************************************
  // tasks
  // ****************************************************
  task automatic check(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
    compares += 1;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors += 1;
    end
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // hold the request until its ready is seen at a rising edge
  task automatic send(input ulpps_row_t r);
    @(negedge clk_sys);
    if (r.to_link) begin
      p_rx_data = r.b;
      p_rx_valid = 1'b1;
    end else begin
      tx_data = r.b;
      tx_last = r.last;
      tx_valid = 1'b1;
    end
    // ready is judged settled at the falling edge, taken at the next rise
    for (k = 0; k < 400; k++) begin
      if ((r.to_link ? p_rx_ready : tx_ready) === 1'b1) break;
      @(negedge clk_sys);
    end
    if (k == 400) begin
      n_errors += 1;
      report_and_stop();
    end
    @(posedge clk_sys);
    if (r.last) begin
      @(negedge clk_sys);
      p_rx_valid = 1'b0;
      tx_valid = 1'b0;
    end
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (5) @(negedge clk_sys);
    reset = 1'b0;
    `CHK("dir idle", 9'h000, {8'h00, u_ulpps_if.dir});
    `CHK("nxt idle", 9'h000, {8'h00, u_ulpps_if.nxt});
    `CHK("stp idle", 9'h000, {8'h00, u_ulpps_if.stp});
    repeat (6) @(negedge clk_sys);
    // ordinary streams from the row table, both directions
    foreach (rows[i]) begin
      if (rows[i].to_link) exp_rx.push_back(rows[i].b);
      else exp_cmd.push_back({rows[i].last, rows[i].b});
      send(rows[i]);
    end
    for (k = 0; k < 3000; k++) begin
      if (got_cmd.size() >= exp_cmd.size() &&
          got_rx.size() >= exp_rx.size()) break;
      @(negedge clk_sys);
    end
    if (k == 3000) n_errors += 1;
    `CHK("cmd count", exp_cmd.size(), got_cmd.size());
    `CHK("rx count", exp_rx.size(), got_rx.size());
    foreach (exp_cmd[i])
      if (i < got_cmd.size()) `CHK("cmd byte", exp_cmd[i], got_cmd[i]);
    foreach (exp_rx[i])
      if (i < got_rx.size()) `CHK("rx byte", exp_rx[i], got_rx[i]);
    // chip reset low: every phy enable off and the clock parked low
    chip_reset_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    `CHK("data oe", 9'h000, {8'h00, u_ulpps_if.phy_data_oe});
    `CHK("dir oe", 9'h000, {8'h00, u_ulpps_if.dir_oe});
    `CHK("nxt oe", 9'h000, {8'h00, u_ulpps_if.nxt_oe});
    `CHK("clock out", 9'h000, {8'h00, pclk});
    chip_reset_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    `CHK("dir oe on", 9'h001, {8'h00, u_ulpps_if.dir_oe});
    `CHK("nxt oe on", 9'h001, {8'h00, u_ulpps_if.nxt_oe});
    report_and_stop();
  end
endmodule

// ### ulpps_fifo.sv
// parameterised valid/ready fifo used in the outbound data path of the phy end
`timescale 1ns/10ps
module ulpps_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic do_wr;
  logic do_rd;
  // full and empty straight from the occupancy count
  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;
  assign out_data = mem[rd_ptr];
  // storage, written only when space exists
  always_ff @(posedge clk_sys) begin
    if (do_wr) begin
      mem[wr_ptr] <= in_data;
    end
  end
  // pointers and count
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (do_rd) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// ### ulpps_if.sv
// interface carrying the twelve ulpi pins between phy and link
`timescale 1ns/10ps
interface ulpps_if;
  import ulpps_pkg::*;
  logic ifclk;
  logic dir;
  logic dir_oe;
  logic nxt;
  logic nxt_oe;
  logic stp;
  logic [7:0] phy_data_o;
  logic phy_data_oe;
  logic [7:0] link_data_o;
  logic link_data_oe;
  logic [7:0] data;
  // resolved wire level; phy wins only if both drive (a fault)
  assign data = phy_data_oe ? phy_data_o :
                (link_data_oe ? link_data_o : 8'h00);
  modport phy (
    output ifclk, dir, dir_oe, nxt, nxt_oe, phy_data_o, phy_data_oe,
    input stp, data
  );
  modport link (
    input ifclk, dir, nxt, data,
    output stp, link_data_o, link_data_oe
  );
endinterface

// ### ulpps_link.sv
// link end: sends command streams, ends them with stp, takes phy data
`timescale 1ns/10ps
module ulpps_link (
  input wire logic clk_sys,
  input wire logic reset,
  ulpps_if.link bus,
  input wire ulpps_pkg::ulpps_byte_t tx_data,
  input wire logic tx_valid,
  input wire logic tx_last,
  output logic tx_ready,
  output ulpps_pkg::ulpps_byte_t rx_data,
  output logic rx_valid
);
  import ulpps_pkg::*;
  // ****************************************************
  // interface clock edge detect through three stages
  // ****************************************************
  logic [2:0] clk_sync;
  logic dir_prev;
  logic rise;
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      clk_sync <= 3'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], bus.ifclk};
    end
  end
  assign rise = clk_sync[2] == 1'b0 && clk_sync[1] == 1'b1;
  // ****************************************************
  // transmit state machine
  // ****************************************************
  ulpps_link_state_t state;
  ulpps_byte_t dout;
  logic drive;
  logic stp_q;
  logic last_q;
  assign tx_ready = rise && !bus.dir && !dir_prev &&
                    ((state == ULPPS_L_IDLE) ||
                     (state == ULPPS_L_SEND && bus.nxt && !last_q));
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= ULPPS_L_IDLE;
      dout <= ULPPS_DATA_RST;
      drive <= 1'b0;
      stp_q <= 1'b0;
      last_q <= 1'b0;
      dir_prev <= 1'b0;
    end else if (rise) begin
      dir_prev <= bus.dir;
      stp_q <= 1'b0;
      case (state)
        ULPPS_L_IDLE: begin
          // no driving in the turnaround cycle after dir falls
          if (tx_valid && tx_ready) begin
            drive <= 1'b1;
            dout <= tx_data;
            last_q <= tx_last;
            state <= ULPPS_L_SEND;
          end
        end
        ULPPS_L_SEND: begin
          if (bus.dir) begin
            drive <= 1'b0;
            state <= ULPPS_L_IDLE;
          end else if (bus.nxt) begin
            if (last_q) begin
              drive <= 1'b0;
              stp_q <= 1'b1;
              state <= ULPPS_L_STOP;
            end else if (tx_valid) begin
              dout <= tx_data;
              last_q <= tx_last;
            end
          end
        end
        ULPPS_L_STOP: begin
          state <= ULPPS_L_IDLE;
        end
        default: begin
          state <= ULPPS_L_IDLE;
        end
      endcase
    end
  end
  // receive bytes from phy after the turnaround cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rx_data <= ULPPS_DATA_RST;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= rise && bus.dir && dir_prev;
      if (rise && bus.dir && dir_prev) begin
        rx_data <= bus.data;
      end
    end
  end
  assign bus.stp = stp_q;
  assign bus.link_data_o = dout;
  assign bus.link_data_oe = drive && !bus.dir;
endmodule

// ### ulpps_phy.sv
// phy end: clock out, dir ownership, nxt throttle, stp handling
`timescale 1ns/10ps
// Function
// - drive interface clock, launch on rising edge
// - eight bit bidirectional bus, bit7 msb
// - nxt high accepts byte from link
// - link presents next byte after nxt
// - dir high when phy owns bus
// - dir low releases bus, watch commands
// - link pulses stp one cycle
// - stp means last byte was previous cycle
// - chip reset low tri-states all i/o; here the interface clock output is driven low instead
// - system supplies reference clock input
// - commands in band over twelve pins
module ulpps_phy (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic chip_reset_n,
  input wire logic ref_clock_input,
  ulpps_if.phy bus,
  output logic phy_interface_clock_out,
  input wire ulpps_pkg::ulpps_byte_t rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  output ulpps_pkg::ulpps_byte_t cmd_data,
  output logic cmd_valid,
  output logic cmd_last,
  input wire logic cmd_ready
);
  import ulpps_pkg::*;
  // ****************************************************
  // pin synchronisers
  // ****************************************************
  logic [2:0] rstn_sync;
  logic run;
  // chip reset is a pin: three stages, change once last two agree
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rstn_sync <= 3'h0;
    end else begin
      rstn_sync <= {rstn_sync[1:0], chip_reset_n};
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      run <= 1'b0;
    end else if (rstn_sync[2] == rstn_sync[1]) begin
      run <= rstn_sync[1];
    end
  end
  // reference clock is only observed; no logic here uses it
  logic unused_ref;
  assign unused_ref = ref_clock_input;
  // ****************************************************
  // interface clock divider
  // ****************************************************
  logic [1:0] div_cnt;
  logic clk_out;
  logic tick;
  // a divided clock, since clk_sys is the only real clock here
  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      div_cnt <= 2'h0;
      clk_out <= 1'b0;
    end else if (div_cnt == 2'(ULPPS_CLK_DIV - 1)) begin
      div_cnt <= 2'h0;
      clk_out <= !clk_out;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end
  assign phy_interface_clock_out = clk_out;
  assign bus.ifclk = clk_out;
  // launch point: the clk_sys edge that raises the interface clock
  assign tick = run && !clk_out && (div_cnt == 2'(ULPPS_CLK_DIV - 1));
  // ****************************************************
  // outbound buffer
  // ****************************************************
  ulpps_byte_t fb_data;
  logic fb_valid;
  logic fb_ready;
  ulpps_fifo #(.WIDTH(ULPPS_DATA_W), .DEPTH(ULPPS_FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(fb_data),
    .out_valid(fb_valid),
    .out_ready(fb_ready)
  );
  // ****************************************************
  // bus ownership state machine
  // ****************************************************
  ulpps_phy_state_t state;
  logic dir_q;
  logic nxt_q;
  ulpps_byte_t dout;
  logic drive;
  logic in_cmd;
  // one byte leaves the fifo per interface cycle, from the turnaround on;
  // popping at the launch keeps the driven byte and the fifo head apart
  assign fb_ready = tick && fb_valid &&
                    (state == ULPPS_TURN_OUT || state == ULPPS_SEND);
  // a nonzero byte or stp on the released bus means the link is talking
  function automatic logic link_talking(input ulpps_byte_t d,
                                        input logic s);
    return (d != 8'h00) || s;
  endfunction
  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      state <= ULPPS_IDLE;
      dir_q <= 1'b0;
      drive <= 1'b0;
      dout <= ULPPS_DATA_RST;
    end else if (tick) begin
      case (state)
        ULPPS_IDLE: begin
          // data to send and link not mid-command: claim the bus;
          // a command starting this very beat wins the bus instead
          if (fb_valid && !in_cmd && !link_talking(bus.data, bus.stp)) begin
            dir_q <= 1'b1;
            state <= ULPPS_TURN_OUT;
          end
        end
        ULPPS_TURN_OUT: begin
          // head of the fifo is popped as it is launched
          drive <= 1'b1;
          dout <= fb_data;
          state <= ULPPS_SEND;
        end
        ULPPS_SEND: begin
          if (fb_valid) begin
            dout <= fb_data;
          end else begin
            // fifo ran dry: hand the bus back
            drive <= 1'b0;
            dir_q <= 1'b0;
            state <= ULPPS_TURN_IN;
          end
        end
        ULPPS_TURN_IN: begin
          state <= ULPPS_IDLE;
        end
        default: begin
          state <= ULPPS_IDLE;
        end
      endcase
    end
  end
  // ****************************************************
  // command hold-back
  // ****************************************************
  // each accepted byte waits one beat, so the stop can mark the
  // last one; costs one beat of latency on every command
  ulpps_byte_t held;
  logic held_ok;
  // ****************************************************
  // receive side: link commands while dir is low
  // ****************************************************
  // nxt accepts the byte on the bus; stalls while a pending cmd_valid meets a low cmd_ready
  always_ff @(posedge clk_sys) begin
    if (reset || !run) begin
      nxt_q <= 1'b0;
      in_cmd <= 1'b0;
      held <= ULPPS_DATA_RST;
      held_ok <= 1'b0;
      cmd_data <= ULPPS_DATA_RST;
      cmd_valid <= 1'b0;
      cmd_last <= 1'b0;
    end else begin
      if (cmd_valid && cmd_ready) begin
        cmd_valid <= 1'b0;
      end
      if (tick) begin
        nxt_q <= 1'b0;
        if (state == ULPPS_IDLE && !dir_q) begin
          if (bus.stp) begin
            // stp ends the stream; last byte was already taken
            in_cmd <= 1'b0;
            held_ok <= 1'b0;
            cmd_data <= held;
            cmd_last <= 1'b1;
            cmd_valid <= held_ok;
          end else if (link_talking(bus.data, 1'b0) || in_cmd) begin
            in_cmd <= 1'b1;
            if (!cmd_valid || cmd_ready) begin
              nxt_q <= 1'b1;
              held <= bus.data;
              held_ok <= 1'b1;
              cmd_data <= held;
              cmd_valid <= held_ok;
              cmd_last <= 1'b0;
            end
          end
        end
      end
    end
  end
  // dir, nxt and data pins released while chip reset holds the part suspended; clock held low
  assign bus.dir = dir_q;
  assign bus.dir_oe = run;
  assign bus.nxt = nxt_q;
  assign bus.nxt_oe = run;
  assign bus.phy_data_o = dout;
  assign bus.phy_data_oe = run && drive;
endmodule

// ### ulpps_pkg.sv
// package with shared constants and types for the ulpi pin signalling ends
package ulpps_pkg;
  // ****************************************************
  // bus geometry
  // ****************************************************
  localparam int ULPPS_DATA_W = 8;
  localparam int ULPPS_FIFO_DEPTH = 32;
  localparam int ULPPS_SYNC_STAGES = 3;
  // ****************************************************
  // clocking: 60 MHz nominal interface clock; a 2.5 MHz stand-in derived from clk_sys
  // ****************************************************
  localparam int ULPPS_SYS_HZ = 10000000;
  localparam int ULPPS_IFCLK_HZ = 60000000;
  localparam int ULPPS_REF_CLOCK_INPUT_HZ = 13000000;
  // a 10 MHz system clock cannot make 60 MHz; toggle every two cycles, divide by four, as stand-in
  localparam int ULPPS_CLK_DIV = 2;
  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] ULPPS_DATA_RST = 8'h00;
  typedef logic [ULPPS_DATA_W-1:0] ulpps_byte_t;
  typedef enum {
    ULPPS_IDLE,
    ULPPS_TURN_OUT,
    ULPPS_SEND,
    ULPPS_TURN_IN
  } ulpps_phy_state_t;
  typedef enum {
    ULPPS_L_IDLE,
    ULPPS_L_SEND,
    ULPPS_L_STOP
  } ulpps_link_state_t;
endpackage

// ### ulpps_props.sv
// checker of the ulpi pin rules between the phy end and the link end
`timescale 1ns/10ps
module ulpps_props (
  input wire logic reset,
  input wire logic ifclk,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp,
  input wire logic phy_data_oe,
  input wire logic link_data_oe
);
  // ****************************************************
  // bus ownership and turnaround
  // ****************************************************
  // judged at the interface clock rise, where the phy launches; the link launches one clk_sys cycle before it
  default clocking cb @(posedge ifclk); endclocking
  default disable iff (reset);
  property p_no_clash;
    !(phy_data_oe && link_data_oe);
  endproperty
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive the data bus");
  property p_phy_owns;
    phy_data_oe |-> dir;
  endproperty
  a_phy_owns: assert property (p_phy_owns)
    else $error("phy drives data while dir is low");
  property p_link_quiet;
    dir |-> !link_data_oe;
  endproperty
  a_link_quiet: assert property (p_link_quiet)
    else $error("link drives data while dir is high");
  property p_turn_out;
    $rose(dir) |-> !phy_data_oe;
  endproperty
  a_turn_out: assert property (p_turn_out)
    else $error("phy drives data in the turnaround cycle");
  property p_turn_in;
    $fell(dir) |-> !link_data_oe && !phy_data_oe;
  endproperty
  a_turn_in: assert property (p_turn_in)
    else $error("data driven in the turnaround after dir fell");
  // ****************************************************
  // throttle and stop
  // ****************************************************
  property p_stp_pulse;
    stp |=> !stp;
  endproperty
  a_stp_pulse: assert property (p_stp_pulse)
    else $error("stop held longer than one cycle");
  // the link answers inside the same interface beat, so the nxt of
  // the last byte and the stop are sampled at one rise
  property p_stp_after_nxt;
    stp |-> nxt;
  endproperty
  a_stp_after_nxt: assert property (p_stp_after_nxt)
    else $error("stop without an accepted last byte before it");
  property p_next_byte;
    nxt |-> link_data_oe || stp;
  endproperty
  a_next_byte: assert property (p_next_byte)
    else $error("link gave no byte nor stop after nxt");
  property p_nxt_inbound;
    nxt |-> !dir;
  endproperty
  a_nxt_inbound: assert property (p_nxt_inbound)
    else $error("nxt raised while phy owns the bus");
  c_stp: cover property (stp);
  c_dir: cover property ($rose(dir));
  c_nxt: cover property (nxt);
endmodule
